/* File: design/jtap_pkg.sv */
// shared constants, states and carriers of the test access port
package jtap_pkg;

   // ----------------------------------------------------------------
   // instruction register
   // ----------------------------------------------------------------
   localparam int IR_W = 4;
   localparam logic [IR_W-1:0] IR_BYPASS = 4'hf;
   localparam logic [IR_W-1:0] IR_IDCODE = 4'h2;
   localparam logic [IR_W-1:0] IR_USER = 4'h8;
   // fixed 01 in the low bits lets a tester check the chain length
   localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
   localparam logic [IR_W-1:0] IR_RESET = IR_IDCODE;

   // ----------------------------------------------------------------
   // sixteen controller states, gray along the main scan walk
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_RESET      = 4'h0,
      ST_IDLE       = 4'h1,
      ST_SEL_DR     = 4'h3,
      ST_CAPTURE_DR = 4'h2,
      ST_SHIFT_DR   = 4'h6,
      ST_EXIT1_DR   = 4'h7,
      ST_PAUSE_DR   = 4'h5,
      ST_EXIT2_DR   = 4'h4,
      ST_UPDATE_DR  = 4'hc,
      ST_SEL_IR     = 4'hd,
      ST_CAPTURE_IR = 4'hf,
      ST_SHIFT_IR   = 4'he,
      ST_EXIT1_IR   = 4'ha,
      ST_PAUSE_IR   = 4'hb,
      ST_EXIT2_IR   = 4'h9,
      ST_UPDATE_IR  = 4'h8
   } jtap_state_t;

   // ----------------------------------------------------------------
   // pin carrier and its value while the synchroniser is in reset
   // ----------------------------------------------------------------
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } jtap_pins_t;

   localparam jtap_pins_t PINS_RESET = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};

endpackage : jtap_pkg

/* File: design/jtap_fifo.sv */
// word fifo between the scan chain and the core side
`timescale 1ns/100ps
`default_nettype none

module jtap_fifo #(
   parameter int W = 32,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [W-1:0] mem_ff [DEPTH];
   logic [AW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
   logic [AW:0] cnt_ff, nxt_cnt;
   logic do_wr, do_rd;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : bump

   assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data = mem_ff[rd_ff];
   assign do_wr = in_valid & in_ready;
   assign do_rd = out_valid & out_ready;

   always_comb begin
      nxt_wr = do_wr ? bump(wr_ff) : wr_ff;
      nxt_rd = do_rd ? bump(rd_ff) : rd_ff;
      nxt_cnt = cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         wr_ff <= nxt_wr;
         rd_ff <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

   // storage needs no reset; empty flag guards reads
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem_ff[wr_ff] <= in_data;
      end
   end

endmodule : jtap_fifo
`default_nettype wire

/* File: design/jtap_top.sv */
// boundary-scan test access port sampled on the system clock
`timescale 1ns/100ps
`default_nettype none

module jtap_top #(
   parameter int DATA_W = 32,
   parameter int FIFO_DEPTH = 16,
   // identity value is arbitrary; bit 0 must stay set
   parameter logic [31:0] ID_VALUE = 32'h0000_0001
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // test port pins
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   input wire logic trst_n,
   output logic tdo_o,
   output logic tdo_oe,
   // scanned words toward the core
   output logic word_valid,
   input wire logic word_ready,
   output logic [DATA_W-1:0] word_data
);
   localparam int DW = (DATA_W > 32) ? DATA_W : 32;

   // ----------------------------------------------------------------
   // pin synchroniser and edge finder
   // ----------------------------------------------------------------
   jtap_pkg::jtap_pins_t pin_s1_ff, pin_s2_ff, pins_in;
   logic tck_d_ff;
   logic tck_rise, tck_fall, trst_act;

   assign pins_in = '{tck: tck, tms: tms, tdi: tdi, trst_n: trst_n};

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_s1_ff <= jtap_pkg::PINS_RESET;
         pin_s2_ff <= jtap_pkg::PINS_RESET;
         tck_d_ff <= 1'b0;
      end else begin
         pin_s1_ff <= pins_in;
         pin_s2_ff <= pin_s1_ff;
         tck_d_ff <= pin_s2_ff.tck;
      end
   end

   // only the second stage is looked at
   assign tck_rise = pin_s2_ff.tck & ~tck_d_ff;
   assign tck_fall = ~pin_s2_ff.tck & tck_d_ff;
   // reset acts on the system clock, so a stopped test clock cannot block it
   assign trst_act = ~pin_s2_ff.trst_n;

   // ----------------------------------------------------------------
   // controller walk
   // ----------------------------------------------------------------
   function automatic jtap_pkg::jtap_state_t tap_next(input jtap_pkg::jtap_state_t s,
                                                      input logic m);
      case (s)
         jtap_pkg::ST_RESET:      tap_next = m ? jtap_pkg::ST_RESET : jtap_pkg::ST_IDLE;
         jtap_pkg::ST_IDLE:       tap_next = m ? jtap_pkg::ST_SEL_DR : jtap_pkg::ST_IDLE;
         jtap_pkg::ST_SEL_DR:     tap_next = m ? jtap_pkg::ST_SEL_IR : jtap_pkg::ST_CAPTURE_DR;
         jtap_pkg::ST_CAPTURE_DR: tap_next = m ? jtap_pkg::ST_EXIT1_DR : jtap_pkg::ST_SHIFT_DR;
         jtap_pkg::ST_SHIFT_DR:   tap_next = m ? jtap_pkg::ST_EXIT1_DR : jtap_pkg::ST_SHIFT_DR;
         jtap_pkg::ST_EXIT1_DR:   tap_next = m ? jtap_pkg::ST_UPDATE_DR : jtap_pkg::ST_PAUSE_DR;
         jtap_pkg::ST_PAUSE_DR:   tap_next = m ? jtap_pkg::ST_EXIT2_DR : jtap_pkg::ST_PAUSE_DR;
         jtap_pkg::ST_EXIT2_DR:   tap_next = m ? jtap_pkg::ST_UPDATE_DR : jtap_pkg::ST_SHIFT_DR;
         jtap_pkg::ST_UPDATE_DR:  tap_next = m ? jtap_pkg::ST_SEL_DR : jtap_pkg::ST_IDLE;
         jtap_pkg::ST_SEL_IR:     tap_next = m ? jtap_pkg::ST_RESET : jtap_pkg::ST_CAPTURE_IR;
         jtap_pkg::ST_CAPTURE_IR: tap_next = m ? jtap_pkg::ST_EXIT1_IR : jtap_pkg::ST_SHIFT_IR;
         jtap_pkg::ST_SHIFT_IR:   tap_next = m ? jtap_pkg::ST_EXIT1_IR : jtap_pkg::ST_SHIFT_IR;
         jtap_pkg::ST_EXIT1_IR:   tap_next = m ? jtap_pkg::ST_UPDATE_IR : jtap_pkg::ST_PAUSE_IR;
         jtap_pkg::ST_PAUSE_IR:   tap_next = m ? jtap_pkg::ST_EXIT2_IR : jtap_pkg::ST_PAUSE_IR;
         jtap_pkg::ST_EXIT2_IR:   tap_next = m ? jtap_pkg::ST_UPDATE_IR : jtap_pkg::ST_SHIFT_IR;
         jtap_pkg::ST_UPDATE_IR:  tap_next = m ? jtap_pkg::ST_SEL_DR : jtap_pkg::ST_IDLE;
         default:                 tap_next = jtap_pkg::ST_RESET;
      endcase
   endfunction : tap_next

   function automatic logic is_shift(input jtap_pkg::jtap_state_t s);
      is_shift = (s == jtap_pkg::ST_SHIFT_DR) || (s == jtap_pkg::ST_SHIFT_IR);
   endfunction : is_shift

   // ----------------------------------------------------------------
   // scan registers and output driver
   // ----------------------------------------------------------------
   jtap_pkg::jtap_state_t state_ff, nxt_state;
   logic [jtap_pkg::IR_W-1:0] ir_ff, nxt_ir, irsh_ff, nxt_irsh;
   logic [DW-1:0] drsh_ff, nxt_drsh;
   logic [DATA_W-1:0] push_word_ff, nxt_push_word;
   logic push_ff, nxt_push;
   logic tdo_ff, nxt_tdo, oe_ff, nxt_oe;
   logic fifo_in_ready;
   logic wide_dr;

   // bypass and unknown codes give the one-bit path
   assign wide_dr = (ir_ff == jtap_pkg::IR_IDCODE) || (ir_ff == jtap_pkg::IR_USER);

   always_comb begin
      nxt_state = state_ff;
      nxt_ir = ir_ff;
      nxt_irsh = irsh_ff;
      nxt_drsh = drsh_ff;
      nxt_push_word = push_word_ff;
      nxt_push = 1'b0;
      nxt_tdo = tdo_ff;
      nxt_oe = oe_ff;
      if (trst_act) begin
         nxt_state = jtap_pkg::ST_RESET;
         nxt_ir = jtap_pkg::IR_RESET;
         nxt_oe = 1'b0;
      end else if (tck_rise) begin
         case (state_ff)
            jtap_pkg::ST_RESET: begin
               nxt_ir = jtap_pkg::IR_RESET;
            end
            jtap_pkg::ST_CAPTURE_IR: begin
               nxt_irsh = jtap_pkg::IR_CAPTURE;
            end
            jtap_pkg::ST_SHIFT_IR: begin
               nxt_irsh = {pin_s2_ff.tdi, irsh_ff[jtap_pkg::IR_W-1:1]};
            end
            jtap_pkg::ST_UPDATE_IR: begin
               nxt_ir = irsh_ff;
            end
            jtap_pkg::ST_CAPTURE_DR: begin
               nxt_drsh = '0;
               if (ir_ff == jtap_pkg::IR_IDCODE) begin
                  nxt_drsh[31:0] = ID_VALUE;
               end else if (ir_ff == jtap_pkg::IR_USER) begin
                  // tester sees a full queue before it sends another word
                  nxt_drsh[0] = ~fifo_in_ready;
               end
            end
            jtap_pkg::ST_SHIFT_DR: begin
               if (wide_dr) begin
                  nxt_drsh = {pin_s2_ff.tdi, drsh_ff[DW-1:1]};
               end else begin
                  nxt_drsh[0] = pin_s2_ff.tdi;
               end
            end
            jtap_pkg::ST_UPDATE_DR: begin
               // a word sent into a full queue is dropped, not stalled
               if (ir_ff == jtap_pkg::IR_USER && fifo_in_ready) begin
                  nxt_push = 1'b1;
                  nxt_push_word = drsh_ff[DATA_W-1:0];
               end
            end
            default: begin
            end
         endcase
         nxt_state = tap_next(state_ff, pin_s2_ff.tms);
      end else if (tck_fall) begin
         nxt_oe = is_shift(state_ff);
         if (is_shift(state_ff)) begin
            nxt_tdo = (state_ff == jtap_pkg::ST_SHIFT_IR) ? irsh_ff[0] : drsh_ff[0];
         end
      end
   end

   // nothing but test reset and the one-cycle push pulse moves without an edge, so a parked clock freezes the rest
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= jtap_pkg::ST_RESET;
         ir_ff <= jtap_pkg::IR_RESET;
         irsh_ff <= '0;
         drsh_ff <= '0;
         push_word_ff <= '0;
         push_ff <= 1'b0;
         tdo_ff <= 1'b0;
         oe_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         ir_ff <= nxt_ir;
         irsh_ff <= nxt_irsh;
         drsh_ff <= nxt_drsh;
         push_word_ff <= nxt_push_word;
         push_ff <= nxt_push;
         tdo_ff <= nxt_tdo;
         oe_ff <= nxt_oe;
      end
   end

   assign tdo_o = tdo_ff;
   assign tdo_oe = oe_ff;

   // ----------------------------------------------------------------
   // word queue toward the core
   // ----------------------------------------------------------------
   jtap_fifo #(
      .W(DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(ref_clk),
      .rst(sys_rst),
      .in_valid(push_ff),
      .in_ready(fifo_in_ready),
      .in_data(push_word_ff),
      .out_valid(word_valid),
      .out_ready(word_ready),
      .out_data(word_data)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_rise;
      tck_rise && !trst_act;
   endsequence

   sequence s_update_user;
      s_rise ##0 (state_ff == jtap_pkg::ST_UPDATE_DR) ##0
         (ir_ff == jtap_pkg::IR_USER) ##0 fifo_in_ready;
   endsequence

   a_trst_forces_reset: assert property (
      trst_act |=> (state_ff == jtap_pkg::ST_RESET) && (ir_ff == jtap_pkg::IR_RESET) && !oe_ff)
      else $error("test reset did not force controller reset");

   a_tms_steers_walk: assert property (
      s_rise |=> state_ff == tap_next($past(state_ff), $past(pin_s2_ff.tms)))
      else $error("controller step does not follow mode input");

   a_tdi_into_dr: assert property (
      s_rise ##0 (state_ff == jtap_pkg::ST_SHIFT_DR) ##0 (ir_ff == jtap_pkg::IR_USER)
      |=> drsh_ff[DW-1] == $past(pin_s2_ff.tdi))
      else $error("data input not shifted into data path");

   a_tdo_on_fall: assert property (
      $changed(tdo_ff) |-> $past(tck_fall))
      else $error("data output changed away from a falling edge");

   a_tdo_float_idle: assert property (
      tck_fall && !trst_act && !is_shift(state_ff) |=> !oe_ff)
      else $error("data output driven outside shifting");

   a_oe_rise_shift: assert property (
      $rose(oe_ff) |-> $past(tck_fall)
      && (($past(state_ff) == jtap_pkg::ST_SHIFT_DR)
      || ($past(state_ff) == jtap_pkg::ST_SHIFT_IR)))
      else $error("output enable rose outside a shift state");

   a_hold_while_low: assert property (
      !pin_s2_ff.tck && !tck_d_ff && !trst_act |=> $stable(state_ff) && $stable(drsh_ff)
      && $stable(irsh_ff) && $stable(tdo_ff))
      else $error("test state moved while test clock rested low");

   a_ir_update: assert property (
      s_rise ##0 (state_ff == jtap_pkg::ST_UPDATE_IR) |=> ir_ff == $past(irsh_ff))
      else $error("instruction not loaded at update");

   a_push_on_update: assert property (
      s_update_user |=> push_ff && (push_word_ff == $past(drsh_ff[DATA_W-1:0])) ##1 !push_ff)
      else $error("user word not pushed once at update");

   // ----------------------------------------------------------------
   // single steps, with the expected state or value written out
   // ----------------------------------------------------------------
   // these do not lean on the walk function, so a wrong table entry shows
   sequence s_fall;
      tck_fall && !trst_act;
   endsequence

   a_mode_ends_shift: assert property (
      s_rise ##0 (state_ff == jtap_pkg::ST_SHIFT_DR) ##0 pin_s2_ff.tms
      |=> state_ff == jtap_pkg::ST_EXIT1_DR)
      else $error("mode input did not end data shift");

   a_reset_leaves: assert property (
      s_rise ##0 (state_ff == jtap_pkg::ST_RESET) ##0 !pin_s2_ff.tms
      |=> state_ff == jtap_pkg::ST_IDLE)
      else $error("low mode input did not leave reset state");

   a_dr_bit_out: assert property (
      s_fall ##0 (state_ff == jtap_pkg::ST_SHIFT_DR)
      |=> oe_ff && (tdo_ff == $past(drsh_ff[0])))
      else $error("data path bit not presented at falling edge");

   a_ir_capture: assert property (
      s_rise ##0 (state_ff == jtap_pkg::ST_CAPTURE_IR) |=> irsh_ff == jtap_pkg::IR_CAPTURE)
      else $error("instruction capture value wrong");

   a_id_capture: assert property (
      s_rise ##0 (state_ff == jtap_pkg::ST_CAPTURE_DR) ##0 (ir_ff == jtap_pkg::IR_IDCODE)
      |=> drsh_ff[31:0] == ID_VALUE)
      else $error("identity value not captured");

   // a word sent at full must leave no trace in the queue
   a_full_drops_word: assert property (
      s_rise ##0 (state_ff == jtap_pkg::ST_UPDATE_DR) ##0 (ir_ff == jtap_pkg::IR_USER)
      ##0 !fifo_in_ready |=> !push_ff)
      else $error("word pushed into a full queue");

endmodule : jtap_top
`default_nettype wire

/* File: tb/jtap_tester.sv */
// behavioural boundary-scan tester that drives the test port pins
`timescale 1ns/100ps
`default_nettype none

module jtap_tester (
   // test port pins
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trst_n,
   input wire logic tdo
);
   // ----------------------------------------------------------------
   // idle levels: clock stands low, mode and data at pull-up level
   // ----------------------------------------------------------------
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      trst_n = 1'b0;
   end

   // ----------------------------------------------------------------
   // one 200 ns period; long low phase lets the resynchronised tdo settle
   // ----------------------------------------------------------------
   task automatic step(input logic m, input logic d, output logic q);
      #40;
      tms = m;
      tdi = d;
      #80;
      q = tdo;
      tck = 1'b1;
      #80;
      tck = 1'b0;
      // hold time over: lines fall back to their pull-up level
      tms = 1'b1;
      tdi = 1'b1;
   endtask : step

   task automatic reset_port();
      tms = 1'b1;
      trst_n = 1'b0;
      #300;
      trst_n = 1'b1;
      #300;
   endtask : reset_port

   task automatic go_idle();
      logic q;
      step(1'b0, 1'b1, q);
   endtask : go_idle

   task automatic tms_reset();
      logic q;
      repeat (5) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask : tms_reset

   // ----------------------------------------------------------------
   // idle to idle scan, lsb first; stall rests the clock low mid-frame
   // ----------------------------------------------------------------
   task automatic scan(input logic ir, input logic [31:0] din, input int n, input int stall,
                       output logic [31:0] dout);
      logic q;
      dout = '0;
      step(1'b1, 1'b1, q);
      if (ir) step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
      step(1'b0, 1'b1, q);
      for (int i = 0; i < n; i++) begin
         if (i == n / 2) #(stall);
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, 1'b1, q);
      step(1'b0, 1'b1, q);
   endtask : scan
endmodule : jtap_tester
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench of the test access port with its word queue
`timescale 1ns/100ps
`default_nettype none

module testbench;
   // identity value is arbitrary
   localparam logic [31:0] ID_VAL = 32'h0000_0035;
   logic ref_clk, sys_rst, tck, tms, tdi, trst_n, tdo_o, tdo_oe;
   logic word_valid, word_ready, drain;
   logic [31:0] word_data, seed, rr, got, d, rq;
   logic [3:0] byp[3];
   logic [31:0] exp_q[$];
   wire tdo;
   int errors, checks_done, cycles;

   assign tdo = tdo_oe ? tdo_o : 1'bz;

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   jtap_top #(.ID_VALUE(ID_VAL)) jtap_top_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .tck(tck),
      .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe(tdo_oe),
      .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data));
   jtap_tester jtap_tester_i (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic stop_test();
      if (errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   task automatic cmp_scan(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %0t scan %h exp %h", $time, g, e);
      end
   endtask : cmp_scan

   task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %0t word %h exp %h", $time, g, e);
      end
   endtask : cmp_word

   task automatic cmp_pin(input logic g, input logic e);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %0t pin %h exp %h", $time, g, e);
      end
   endtask : cmp_pin

   task automatic load_ir(input logic [3:0] code);
      jtap_tester_i.scan(1'b1, {28'h0, code}, 4, 0, got);
      cmp_scan(got, {28'h0, jtap_pkg::IR_CAPTURE});
      cmp_pin(tdo_oe, 1'b0);
   endtask : load_ir

   task automatic wait_empty();
      for (int w = 0; w < 3000 && exp_q.size() > 0; w++) @(posedge ref_clk);
      repeat (3) @(posedge ref_clk);
      cmp_pin(word_valid, 1'b0);
   endtask : wait_empty

   // ----------------------------------------------------------------
   // monitors: timeout, word consumer, output edge discipline
   // ----------------------------------------------------------------
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles > 20000) begin
         errors++;
         stop_test();
      end
   end

   // take decided at the falling edge, while the head word stands settled
   always @(negedge ref_clk) begin
      rq = rnd();
      if (word_valid === 1'b1 && drain && rq[0]) begin
         cmp_word(word_data, exp_q.size() > 0 ? exp_q.pop_front() : 32'hx);
      end
      word_ready <= drain && rq[0];
   end

   always @(tdo_o or tdo_oe) begin
      if (sys_rst === 1'b0 && trst_n === 1'b1) cmp_pin(tck, 1'b0);
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 32'h58038edd;
      errors = 0;
      checks_done = 0;
      cycles = 0;
      drain = 1'b0;
      sys_rst = 1'b1;
      byp = '{jtap_pkg::IR_BYPASS, 4'h5, 4'h0};
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      sys_rst = 1'b0;
      jtap_tester_i.reset_port();
      cmp_pin(tdo_oe, 1'b0);
      jtap_tester_i.go_idle();
      // long clock rest in mid-shift must not disturb the chain
      jtap_tester_i.scan(1'b0, rnd(), 32, 5000, got);
      cmp_scan(got, ID_VAL);
      foreach (byp[k]) begin
         load_ir(byp[k]);
         d = rnd();
         jtap_tester_i.scan(1'b0, d, 8, 0, got);
         cmp_scan(got, {24'h0, d[6:0], 1'b0});
      end
      // five high mode bits return to the reset instruction
      jtap_tester_i.tms_reset();
      jtap_tester_i.scan(1'b0, rnd(), 32, 0, got);
      cmp_scan(got, ID_VAL);
      load_ir(jtap_pkg::IR_BYPASS);
      jtap_tester_i.reset_port();
      cmp_pin(tdo_oe, 1'b0);
      jtap_tester_i.go_idle();
      jtap_tester_i.scan(1'b0, rnd(), 32, 0, got);
      cmp_scan(got, ID_VAL);
      // fill past depth: the seventeenth word is dropped and flagged
      load_ir(jtap_pkg::IR_USER);
      for (int k = 0; k < 18; k++) begin
         if (k == 17) begin
            drain = 1'b1;
            wait_empty();
         end
         d = {31'h0, exp_q.size() == 16};
         got = rnd();
         if (exp_q.size() < 16) exp_q.push_back(got);
         jtap_tester_i.scan(1'b0, got, 32, 0, rr);
         cmp_scan(rr, d);
      end
      wait_empty();
      stop_test();
   end
endmodule : testbench
`default_nettype wire
